// ==== hw/dbu_cfg.svh ====
/*
  Constants of the debug breakpoint unit: register indices, field positions,
  encodings, reset values and write masks.
  Assumes inclusion by bare name from every file that needs a figure.
*/
`ifndef DBU_CFG_SVH
`define DBU_CFG_SVH

// ----------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------
`define DBU_IDX_BP0 3'h0
`define DBU_IDX_BP1 3'h1
`define DBU_IDX_BP2 3'h2
`define DBU_IDX_BP3 3'h3
`define DBU_IDX_RSVA 3'h4
`define DBU_IDX_RSVB 3'h5
`define DBU_IDX_STAT 3'h6
`define DBU_IDX_CTRL 3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DBU_TF_BIT 8
`define DBU_IO_PRIVILEGE_LEVEL_LO 12
`define DBU_IO_PRIVILEGE_LEVEL_HI 13
`define DBU_STAT_BD 13
`define DBU_STAT_BS 14
`define DBU_STAT_BT 15
`define DBU_CTRL_LE 8
`define DBU_CTRL_GE 9
`define DBU_CTRL_FLD_LO 16

// ----------------------------------------
// Encodings and vectors
// ----------------------------------------
`define DBU_LEN_1B 2'h0
`define DBU_LEN_2B 2'h1
`define DBU_LEN_4B 2'h3
`define DBU_RW_EXEC 2'h0
`define DBU_RW_WR 2'h1
`define DBU_RW_RDWR 2'h3
`define DBU_VEC_STEP 8'h01
`define DBU_VEC_BRK 8'h03
`define DBU_VEC_PROT 8'h0d
`define DBU_OPC_BRK 8'hcc
`define DBU_OPC_SWI 8'hcd

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define DBU_RST_WORD 32'h0000_0000
`define DBU_STAT_WMASK 32'h0000_e00f
`define DBU_CTRL_WMASK 32'hffff_23ff

`endif

// ==== hw/dbu_pkg.sv ====
/*
  Types and shared decode of the debug breakpoint unit.
  Assumes dbu_cfg.svh is on the include path.
*/
`include "dbu_cfg.svh"

package dbu_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [1:0] dbu_fld_t;
  typedef logic [31:0] dbu_word_t;
  typedef enum logic [1:0] {
    DBU_EXC_NONE,
    DBU_EXC_FAULT,
    DBU_EXC_TRAP
  } dbu_exc_e;

  // ----------------------------------------
  // Length field to compare mask
  // ----------------------------------------
  function automatic dbu_word_t dbu_len_mask(input dbu_fld_t len);
    dbu_word_t m;
    m = 32'hffff_ffff;
    case (len)
      `DBU_LEN_2B: m = 32'hffff_fffe;
      `DBU_LEN_4B: m = 32'hffff_fffc;
      default: m = 32'hffff_ffff;
    endcase
    return m;
  endfunction

endpackage

// ==== hw/dbu_cmp_if.sv ====
/*
  Carrier between the unit's top and one address comparator.
  Assumes one instance per breakpoint.
*/
`timescale 1ns/1ps
`default_nettype none

interface dbu_cmp_if;
  import dbu_pkg::*;
  dbu_word_t bp_addr;
  dbu_fld_t bp_len;
  dbu_fld_t bp_rw;
  logic bp_armed;
  logic hit_exec;
  logic hit_data;
  modport top (output bp_addr, bp_len, bp_rw, bp_armed, input hit_exec, hit_data);
  modport cmp (input bp_addr, bp_len, bp_rw, bp_armed, output hit_exec, hit_data);
endinterface

`default_nettype wire

// ==== hw/dbu_match.sv ====
/*
  One linear-address breakpoint comparator.
  Assumes probe addresses are linear, same clock, combinational compare.
*/
`timescale 1ns/1ps
`default_nettype none

module dbu_match
  import dbu_pkg::*;
(
  dbu_cmp_if.cmp cfg,
  input wire logic ins_start,
  input wire logic [31:0] ins_addr,
  input wire logic dat_valid,
  input wire logic dat_write,
  input wire logic [31:0] dat_addr
);

  // ----------------------------------------
  // Masked compare
  // ----------------------------------------
  wire dbu_word_t mask = dbu_len_mask(cfg.bp_len);
  wire logic ex_eq = (ins_addr & mask) == (cfg.bp_addr & mask);
  wire logic dat_eq = (dat_addr & mask) == (cfg.bp_addr & mask);
  wire logic kind_wr = (cfg.bp_rw == `DBU_RW_WR) && dat_write;
  wire logic kind_rd = (cfg.bp_rw == `DBU_RW_RDWR);

  // Unused encoding 10 never matches, so it cannot fire by accident
  assign cfg.hit_exec = cfg.bp_armed && (cfg.bp_rw == `DBU_RW_EXEC) && ins_start && ex_eq;
  assign cfg.hit_data = cfg.bp_armed && (kind_wr || kind_rd) && dat_valid && dat_eq;

endmodule

`default_nettype wire

// ==== hw/dbu_top.sv ====
/*
  Debug breakpoint unit: breakpoint opcode trap, single-step trap and four
  linear-address breakpoints, with an Avalon-MM register slave.
  Assumes the core pulses ins_start as an instruction is about to execute and
  ins_done when it completes, and reports data accesses between them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbu_cfg.svh"

module dbu_top
  import dbu_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ins_start,
  input wire logic [31:0] ins_addr,
  input wire logic [7:0] ins_opcode,
  input wire logic ins_done,
  input wire logic [31:0] ins_next_addr,
  input wire logic ins_loads_ss,
  input wire logic [31:0] processor_flags_word,
  input wire logic prot_mode,
  input wire logic v86_mode,
  input wire logic [1:0] cur_priv,
  input wire logic task_switch,
  input wire logic dat_valid,
  input wire logic dat_write,
  input wire logic [31:0] dat_addr,
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic exc_is_trap,
  output logic [31:0] return_code_pointer
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic ack_ff;
  logic [31:0] rdata_ff;
  wire logic req = avs_read || avs_write;
  wire logic [2:0] idx = avs_address[4:2];
  wire logic wr_go = avs_write && ack_ff;
  wire logic rd_go = avs_read && ack_ff;
  wire logic [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic wr_stat = wr_go && (idx == `DBU_IDX_STAT);
  wire logic wr_ctrl = wr_go && (idx == `DBU_IDX_CTRL);

  // One wait state: every access ends on the second edge
  assign avs_waitrequest = req && !ack_ff;
  assign avs_readdata = rdata_ff;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  // ----------------------------------------
  // Breakpoint address registers
  // ----------------------------------------
  logic [31:0] bp_ff [4];
  logic [31:0] ctrl_ff;
  logic [31:0] stat_ff;
  logic [3:0] hit_exec;
  logic [3:0] hit_data;
  dbu_cmp_if cmp_bus [4] ();

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bp
      wire logic sel = wr_go && (idx == 3'(gi));
      wire logic [31:0] nxt_bp = (bp_ff[gi] & ~bmask) | (avs_writedata & bmask);

      always_ff @(posedge mclk) begin
        if (!resetn) begin
          bp_ff[gi] <= `DBU_RST_WORD;
        end else if (sel) begin
          bp_ff[gi] <= nxt_bp;
        end
      end

      assign cmp_bus[gi].bp_addr = bp_ff[gi];
      assign cmp_bus[gi].bp_rw = ctrl_ff[`DBU_CTRL_FLD_LO + 4*gi +: 2];
      assign cmp_bus[gi].bp_len = ctrl_ff[`DBU_CTRL_FLD_LO + 4*gi + 2 +: 2];
      assign cmp_bus[gi].bp_armed = ctrl_ff[2*gi] || ctrl_ff[2*gi + 1];
      assign hit_exec[gi] = cmp_bus[gi].hit_exec;
      assign hit_data[gi] = cmp_bus[gi].hit_data;

      // Registers on chip, so no code patching: ROM and shared code both work
      dbu_match u_match (
        .cfg(cmp_bus[gi]),
        .ins_start(ins_start),
        .ins_addr(ins_addr),
        .dat_valid(dat_valid),
        .dat_write(dat_write),
        .dat_addr(dat_addr)
      );
    end
  endgenerate

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  wire logic [31:0] ctrl_wmask = bmask & `DBU_CTRL_WMASK;
  wire logic [31:0] ctrl_wr = (ctrl_ff & ~ctrl_wmask) | (avs_writedata & ctrl_wmask);
  wire logic [31:0] ctrl_base = wr_ctrl ? ctrl_wr : ctrl_ff;
  // Task switch drops local enables so a new task starts with them clear
  wire logic [31:0] local_clr = {22'h00_0000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
                                 1'b1, 1'b0, 1'b1};
  wire logic [31:0] nxt_ctrl = task_switch ? (ctrl_base & ~local_clr) : ctrl_base;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_ff <= `DBU_RST_WORD;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ----------------------------------------
  // Instruction tracking
  // ----------------------------------------
  logic step_pend_ff;
  logic brk_pend_ff;
  logic brk_late_ff;
  logic [31:0] brk_ptr_ff;
  logic [3:0] dhit_ff;

  wire logic any_exec = |hit_exec;
  wire logic tf = processor_flags_word[`DBU_TF_BIT];
  wire logic [1:0] io_privilege_level = processor_flags_word[`DBU_IO_PRIVILEGE_LEVEL_HI:`DBU_IO_PRIVILEGE_LEVEL_LO];
  wire logic is_brk = (ins_opcode == `DBU_OPC_BRK);
  // Only the two-byte form is privilege checked; the one-byte form never is
  wire logic swi_blocked = (ins_opcode == `DBU_OPC_SWI) && (prot_mode || v86_mode)
                           && (cur_priv > io_privilege_level);
  wire logic start_ok = ins_start && !any_exec && !swi_blocked;
  wire logic [3:0] dhit_all = dhit_ff | hit_data;
  wire logic data_trap = ins_done && (|dhit_all) && !ins_loads_ss;
  wire logic step_trap = ins_done && step_pend_ff && !ins_loads_ss;
  wire logic brk_now = ins_done && brk_pend_ff && !data_trap && !step_trap;
  wire logic brk_after = ins_done && brk_pend_ff && (data_trap || step_trap);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      step_pend_ff <= 1'b0;
      brk_pend_ff <= 1'b0;
      dhit_ff <= 4'h0;
    end else if (ins_start) begin
      step_pend_ff <= start_ok && tf;
      brk_pend_ff <= start_ok && is_brk;
      dhit_ff <= hit_data;
    end else if (ins_done) begin
      step_pend_ff <= 1'b0;
      brk_pend_ff <= 1'b0;
      dhit_ff <= 4'h0;
    end else begin
      dhit_ff <= dhit_all;
    end
  end

  // A breakpoint opcode that shares a boundary with a vector 1 trap follows it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      brk_late_ff <= 1'b0;
      brk_ptr_ff <= `DBU_RST_WORD;
    end else begin
      brk_late_ff <= brk_after;
      brk_ptr_ff <= ins_next_addr;
    end
  end

  // ----------------------------------------
  // Exception report
  // ----------------------------------------
  dbu_exc_e kind;
  wire logic fault_exec = ins_start && any_exec;
  wire logic fault_prot = ins_start && !any_exec && swi_blocked;
  wire logic trap_step = data_trap || step_trap;
  wire logic trap_brk = brk_now || brk_late_ff;

  assign kind = (fault_exec || fault_prot) ? DBU_EXC_FAULT :
                (trap_step || trap_brk) ? DBU_EXC_TRAP : DBU_EXC_NONE;

  wire logic [7:0] nxt_vec = fault_exec ? `DBU_VEC_STEP :
                             fault_prot ? `DBU_VEC_PROT :
                             trap_step ? `DBU_VEC_STEP : `DBU_VEC_BRK;
  // Faults point at the instruction itself, traps at the next one
  wire logic [31:0] nxt_ptr = (kind == DBU_EXC_FAULT) ? ins_addr :
                              (trap_step || brk_now) ? ins_next_addr : brk_ptr_ff;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      exc_valid <= 1'b0;
      exc_vector <= 8'h00;
      exc_is_trap <= 1'b0;
      return_code_pointer <= `DBU_RST_WORD;
    end else begin
      exc_valid <= (kind != DBU_EXC_NONE);
      exc_vector <= nxt_vec;
      exc_is_trap <= (kind == DBU_EXC_TRAP);
      return_code_pointer <= nxt_ptr;
    end
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  wire logic [31:0] stat_wmask = bmask & `DBU_STAT_WMASK;
  wire logic [31:0] stat_base = wr_stat ?
                                ((stat_ff & ~stat_wmask) | (avs_writedata & stat_wmask)) :
                                stat_ff;
  wire logic [3:0] b_set = (fault_exec ? hit_exec : 4'h0) | (data_trap ? dhit_all : 4'h0);
  wire logic [31:0] stat_set = {16'h0000, 1'b0, step_trap, 10'h000, b_set};
  // Hardware set wins over a software clear in the same cycle
  wire logic [31:0] nxt_stat = stat_base | stat_set;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stat_ff <= `DBU_RST_WORD;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `DBU_IDX_BP0: rd_mux = bp_ff[0];
      `DBU_IDX_BP1: rd_mux = bp_ff[1];
      `DBU_IDX_BP2: rd_mux = bp_ff[2];
      `DBU_IDX_BP3: rd_mux = bp_ff[3];
      `DBU_IDX_STAT: rd_mux = stat_ff;
      `DBU_IDX_CTRL: rd_mux = ctrl_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_ff <= `DBU_RST_WORD;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  wire logic unused_rd = rd_go;

endmodule

`default_nettype wire

// ==== testbench/dbu_top_checker.sv ====
/*
  Port-level assertions for the debug breakpoint unit.
  Assumes binding to dbu_top and the core order start, data, done.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbu_cfg.svh"

module dbu_top_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic ins_start,
  input wire logic [31:0] ins_addr,
  input wire logic [7:0] ins_opcode,
  input wire logic ins_done,
  input wire logic [31:0] ins_next_addr,
  input wire logic ins_loads_ss,
  input wire logic [31:0] processor_flags_word,
  input wire logic exc_valid,
  input wire logic [7:0] exc_vector,
  input wire logic exc_is_trap,
  input wire logic [31:0] return_code_pointer
);
  // ------
  // Helpers
  // ------
  logic [7:0] opc_ff;
  logic tf_ff;
  logic armed_ff;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      opc_ff <= 8'h00;
      tf_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      if (ins_start) opc_ff <= ins_opcode;
      if (ins_start) tf_ff <= processor_flags_word[`DBU_TF_BIT];
      if (avs_write && !avs_waitrequest && avs_address[4:2] == `DBU_IDX_CTRL) armed_ff <= 1'b1;
    end
  end
  // ------
  // Assertions
  // ------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_wait_once;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_step_report;
    exc_valid && exc_is_trap && exc_vector == `DBU_VEC_STEP;
  endsequence
  a_wait_once: assert property ($rose(avs_read || avs_write) |-> s_wait_once)
    else $error("bus answer not after one wait state");
  a_brk_trap: assert property (ins_done && opc_ff == `DBU_OPC_BRK |-> ##[1:2]
    (exc_valid && exc_is_trap && exc_vector == `DBU_VEC_BRK)) else $error("no vector 3 trap");
  a_brk_no_priv: assert property (ins_start && ins_opcode == `DBU_OPC_BRK |=>
    !(exc_valid && exc_vector == `DBU_VEC_PROT)) else $error("breakpoint opcode was refused");
  a_step_trap: assert property (ins_done && tf_ff && !ins_loads_ss |=> s_step_report ##0
    return_code_pointer == $past(ins_next_addr)) else $error("step trap wrong");
  a_ss_mask: assert property (ins_done && ins_loads_ss && opc_ff != `DBU_OPC_BRK |=>
    !exc_valid) else $error("trap after stack segment load");
  a_fault_first: assert property (exc_valid && !exc_is_trap |-> $past(ins_start) &&
    return_code_pointer == $past(ins_addr)) else $error("fault not at instruction start");
  a_trap_late: assert property (exc_valid && exc_is_trap |-> $past(ins_done) ||
    $past(ins_done, 2)) else $error("trap not after completion");
  a_no_arm: assert property (!armed_ff |-> !(exc_valid && !exc_is_trap &&
    exc_vector == `DBU_VEC_STEP)) else $error("breakpoint fired before programming");
endmodule

bind dbu_top dbu_top_checker chk_u (.mclk, .resetn, .avs_address, .avs_read, .avs_write,
  .avs_waitrequest, .ins_start, .ins_addr, .ins_opcode, .ins_done, .ins_next_addr,
  .ins_loads_ss, .processor_flags_word, .exc_valid, .exc_vector, .exc_is_trap,
  .return_code_pointer);

`default_nettype wire

// ==== testbench/dbu_core_model.sv ====
/*
  Core execution model: start, one optional data access, done.
  Assumes callers enter run right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module dbu_core_model (
  input wire logic mclk,
  output logic ins_start = 1'b0,
  output logic [31:0] ins_addr = 32'h0000_0000,
  output logic [7:0] ins_opcode = 8'h00,
  output logic ins_done = 1'b0,
  output logic [31:0] ins_next_addr = 32'h0000_0000,
  output logic ins_loads_ss = 1'b0,
  output logic dat_valid = 1'b0,
  output logic dat_write = 1'b0,
  output logic [31:0] dat_addr = 32'h0000_0000
);
  // Released buses show the inverse, so stale values never match by luck
  task automatic run(input logic [31:0] a, input logic [7:0] op, input bit ss, dv, dw,
                     input logic [31:0] da);
    @(posedge mclk);
    ins_start <= 1'b1;
    ins_addr <= a;
    ins_opcode <= op;
    @(posedge mclk);
    ins_start <= 1'b0;
    ins_addr <= ~a;
    ins_opcode <= ~op;
    dat_valid <= dv;
    dat_write <= dw;
    dat_addr <= da;
    @(posedge mclk);
    dat_valid <= 1'b0;
    dat_addr <= ~da;
    ins_done <= 1'b1;
    ins_next_addr <= a + 32'h0000_0004;
    ins_loads_ss <= ss;
    @(posedge mclk);
    ins_done <= 1'b0;
    ins_next_addr <= ~a;
    ins_loads_ss <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ==== testbench/debug_breakpoint_unit_test.sv ====
/*
  Self-checking bench: register model plus event model against the unit.
  Assumes one wait state bus; task switch and virtual mode low except in their own scenarios.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbu_cfg.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end

module debug_breakpoint_unit_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] processor_flags_word = 32'h0000_0000;
  logic prot_mode = 1'b0;
  logic v86_mode = 1'b0;
  logic task_switch = 1'b0;
  logic [1:0] cur_priv = 2'h0;
  wire logic ins_start, ins_done, ins_loads_ss, dat_valid, dat_write;
  wire logic [31:0] ins_addr, ins_next_addr, dat_addr;
  wire logic [7:0] ins_opcode;
  logic exc_valid, exc_is_trap;
  logic [7:0] exc_vector;
  logic [31:0] return_code_pointer, q, b;
  logic [31:0] rm[8];
  logic [40:0] evq[$], expq[$];
  int miscompares = 0;
  int checks_done = 0;

  always #25 mclk = ~mclk;

  dbu_core_model core_u (.mclk, .ins_start, .ins_addr, .ins_opcode, .ins_done,
    .ins_next_addr, .ins_loads_ss, .dat_valid, .dat_write, .dat_addr);
  dbu_top dut_u (.mclk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .ins_start, .ins_addr,
    .ins_opcode, .ins_done, .ins_next_addr, .ins_loads_ss, .processor_flags_word,
    .prot_mode, .v86_mode, .cur_priv, .task_switch, .dat_valid, .dat_write,
    .dat_addr, .exc_valid, .exc_vector, .exc_is_trap, .return_code_pointer);

  // Sampled mid-cycle so the pulse has settled
  always @(negedge mclk) if (exc_valid === 1'b1)
    evq.push_back({exc_is_trap, exc_vector, return_code_pointer});

  // ------
  // Bus and model
  // ------
  task automatic bus(input bit wr, input int w, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= 5'(w * 4);
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input int w, input logic [31:0] d);
    bus(1'b1, w, d);
    if (w < 4) rm[w] = d;
    if (w == 6) rm[6] = d & `DBU_STAT_WMASK;
    if (w == 7) rm[7] = d & `DBU_CTRL_WMASK;
  endtask

  task automatic rd(input int w);
    bus(1'b0, w, 32'h0000_0000);
    `CHK(q, rm[w])
  endtask

  function automatic bit hit(int i, logic [31:0] a, int k);
    logic [1:0] rw, ln;
    logic [31:0] m;
    rw = rm[7][16 + 4 * i +: 2];
    ln = rm[7][18 + 4 * i +: 2];
    m = ln == 2'h1 ? 32'hffff_fffe : ln == 2'h3 ? 32'hffff_fffc : 32'hffff_ffff;
    if (rm[7][2 * i +: 2] == 2'h0 || ((rm[i] ^ a) & m) != 32'h0000_0000) return 0;
    return k == 0 ? rw == 2'h0 : k == 2 ? rw[0] : rw == 2'h3;
  endfunction

  task automatic ins(input logic [31:0] a, input logic [7:0] op, input bit ss, dv, dw,
                     input logic [31:0] da);
    bit f, t;
    core_u.run(a, op, ss, dv, dw, da);
    f = 0;
    t = processor_flags_word[8] && !ss;
    if (t) rm[6][14] = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (hit(i, a, 0)) rm[6][i] = 1'b1;
      if (hit(i, a, 0)) f = 1;
      if (dv && !ss && hit(i, da, dw ? 2 : 1)) rm[6][i] = 1'b1;
      if (dv && !ss && hit(i, da, dw ? 2 : 1)) t = 1;
    end
    if (f) expq.push_back({1'b0, `DBU_VEC_STEP, a});
    if (op == `DBU_OPC_SWI && (prot_mode || v86_mode) && cur_priv > processor_flags_word[13:12])
      expq.push_back({1'b0, `DBU_VEC_PROT, a});
    if (t) expq.push_back({1'b1, `DBU_VEC_STEP, a + 32'h0000_0004});
    if (op == `DBU_OPC_BRK) expq.push_back({1'b1, `DBU_VEC_BRK, a + 32'h0000_0004});
    repeat (4) @(posedge mclk);
    `CHK(evq.size(), expq.size())
    foreach (expq[k]) `CHK(evq[k], expq[k])
    evq = {};
    expq = {};
  endtask

  task automatic final_report;
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ------
  // Scenarios
  // ------
  initial begin
    void'($urandom(3971));
    for (int w = 0; w < 8; w++) rm[w] = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    for (int w = 0; w < 8; w++) rd(w);
    for (int w = 0; w < 4; w++) wr(w, $urandom());
    for (int w = 0; w < 8; w++) rd(w);
    ins(rm[0], 8'h90, 0, 1, 1, rm[1]);
    for (int j = 0; j < 3; j++) begin
      b = $urandom();
      wr(j, b);
      wr(7, (32'(j == 2 ? 3 : j) << (18 + 4 * j)) | (32'(j == 1 ? 2 : 1) << (2 * j)));
      for (int o = 0; o < 4; o++) ins(b ^ 32'(o), 8'h90, 0, 0, 0, 0);
      rd(6);
      wr(6, 32'h0000_0000);
    end
    // Task switch drops local enables only; the global one keeps breakpoint 1 armed
    wr(7, 32'h0000_0009);
    task_switch <= 1'b1;
    @(posedge mclk);
    task_switch <= 1'b0;
    rm[7] = rm[7] & ~32'h0000_0155;
    rd(7);
    ins(rm[0], 8'h90, 0, 0, 0, 0);
    ins(rm[1], 8'h90, 0, 0, 0, 0);
    b = $urandom();
    wr(3, b);
    wr(7, 32'h1000_0080);
    ins(32'h0000_2000, 8'h90, 0, 1, 0, b);
    ins(32'h0000_2000, 8'h90, 0, 1, 1, b);
    ins(32'h0000_2000, 8'h90, 0, 1, 1, b ^ 32'h0000_0001);
    wr(7, 32'h3000_0080);
    ins(32'h0000_2000, 8'h90, 0, 1, 0, b);
    ins(32'h0000_2000, 8'h90, 1, 1, 0, b);
    rd(6);
    wr(6, 32'h0000_0000);
    processor_flags_word <= 32'h0000_0100;
    ins(32'h0000_3000, 8'h90, 0, 0, 0, 0);
    ins(32'h0000_3004, 8'h90, 1, 0, 0, 0);
    rd(6);
    processor_flags_word <= 32'h0000_0000;
    prot_mode <= 1'b1;
    cur_priv <= 2'h3;
    ins(32'h0000_4000, `DBU_OPC_BRK, 0, 0, 0, 0);
    ins(32'h0000_4004, `DBU_OPC_SWI, 0, 0, 0, 0);
    prot_mode <= 1'b0;
    v86_mode <= 1'b1;
    ins(32'h0000_4008, `DBU_OPC_SWI, 0, 0, 0, 0);
    ins(32'h0000_400c, `DBU_OPC_BRK, 0, 0, 0, 0);
    cur_priv <= 2'h0;
    ins(32'h0000_4010, `DBU_OPC_SWI, 0, 0, 0, 0);
    final_report;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("unexpected at %0t: run did not finish", $time);
    final_report;
  end
endmodule

`default_nettype wire
